// [rtl/mcp_pkg.sv]
// constants and types of the motor-control pwm unit
`default_nettype none
package mcp_pkg;
  localparam int CNT_W = 12;
  localparam int CH_N = 6;
  localparam int PAIR_N = 3;
  localparam int DT_W = 8;
  localparam int PS_W = 3;
  localparam int PSC_W = 7;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_MOD = 8'h08;
  localparam logic [7:0] A_MAP = 8'h0C;
  localparam logic [7:0] A_SWC = 8'h10;
  localparam logic [7:0] A_DT = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_VAL0 = 8'h20;
  localparam logic [7:0] A_VSTEP = 8'h04;
  // pwm_control_one fields
  localparam int B_RUN = 0;
  localparam int B_LDE = 1;
  localparam int B_FLAG = 2;
  localparam int B_IEN = 3;
  localparam int B_CLO = 4;
  localparam int B_CHI = 5;
  localparam int B_BANK_Y_SOFT_DISABLE = 6;
  localparam int B_BANK_X_SOFT_DISABLE = 7;
  // configuration fields
  localparam int B_CTR = 0;
  localparam int B_IND = 1;
  localparam int F_PS = 2;
  // disable map fields: bank x low half, bank y high half
  localparam int F_MAPY = 6;
  localparam int STAT_SENS = 12;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [CNT_W-1:0] MOD_RST = 12'hFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [1:0] HTRANS_NSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {CORR_NONE, CORR_SW, CORR_PIN, CORR_LAT} mcp_corr_t;
endpackage
`default_nettype wire

// [rtl/mcp_unit.sv]
// six-channel motor-control pwm generator with ahb-lite registers
//
// Register access over AHB-Lite and the register addresses were decided locally.
`default_nettype none
// Contract
// R1 - one 12-bit counter is the timebase for all six channels.
// R2 - resolution is one counter tick edge-aligned, two ticks center-aligned.
// R3 - counter tick is the operating clock divided by a programmable prescaler.
// R4 - three complementary pairs or six independent outputs, center or edge aligned.
// R5 - complementary pairs get dead time before either output turns on.
// R6 - pair duty switches between two values by sensed current polarity.
// R7 - top/bottom correction driven by sense inputs or software bits.
// R8 - control register governs enable, value loading and correction method.
// R9 - software disable forces mapped outputs to their inactive state.
// R10 - bank x disable acts at once; re-enable waits for next cycle start.
// R11 - bank y disable acts at once; re-enable waits for next cycle start.
// R12 - the disable map register accepts only its first write.
// R13 - with irq enable set, a set reload flag holds the interrupt pending.
// R14 - clearing irq enable blocks the pending reload interrupt.
// R15 - reload flag sets at every reload cycle start, load enable or not.
// R16 - flag clears only after a read seeing it set, then a zero write.
// R17 - a reload between that read and the write voids the zero write.
// R18 - clearing the flag withdraws the reload interrupt, nothing else.
// R19 - a two-bit control field selects the correction scheme.
// R20 - edge mode counts 1 to modulus; center counts up then down.
// R21 - new modulus, prescaler, duty take effect at reload only with load enable.
module mcp_unit
  import mcp_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [mcp_pkg::PAIR_N-1:0] cur_sense,
  output logic [mcp_pkg::CH_N-1:0] pwm_out,
  output logic reload_irq
);
  import mcp_pkg::*;

  logic [31:0] hrdata_r;
  logic wr_r;
  logic [7:0] addr_r;
  logic [7:0] ctrl_r;
  logic load_enable_r;
  logic reload_flag_r;
  logic armed_r;
  logic [PS_W+1:0] cfg_r;
  logic [CNT_W-1:0] mod_buf_r, mod_act_r;
  logic [PS_W-1:0] ps_act_r;
  logic [CNT_W-1:0] val_buf_r [CH_N];
  logic [CNT_W-1:0] val_act_r [CH_N];
  logic [2*CH_N-1:0] map_r;
  logic map_done_r;
  logic [PAIR_N-1:0] swc_r;
  logic [DT_W-1:0] dt_r;
  logic [PAIR_N-1:0] sens_m_r, sens_s_r, sens_l_r;
  logic [PSC_W-1:0] psc_r;
  logic [CNT_W-1:0] cnt_r;
  logic down_r;
  logic [CH_N-1:0] mask_r;
  logic [CH_N-1:0] out_r;
  logic [PAIR_N-1:0] raw_prev_r;
  logic [DT_W-1:0] dtc_r [PAIR_N];

  // bus decode: zero wait states, always OKAY
  wire ap = hsel && htrans == HTRANS_NSEQ && hready;
  wire [7:0] ap_addr = haddr[7:0];
  wire wr_ctrl = wr_r && addr_r == A_CTRL;
  wire wr_cfg = wr_r && addr_r == A_CFG;
  wire wr_mod = wr_r && addr_r == A_MOD;
  wire wr_map = wr_r && addr_r == A_MAP;
  wire wr_swc = wr_r && addr_r == A_SWC;
  wire wr_dt = wr_r && addr_r == A_DT;
  wire rd_ctrl = ap && !hwrite && ap_addr == A_CTRL;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_r;

  // control fields
  wire run = ctrl_r[B_RUN];
  wire center = cfg_r[B_CTR];
  wire indep = cfg_r[B_IND];
  wire mcp_corr_t corr = mcp_corr_t'({ctrl_r[B_CHI], ctrl_r[B_CLO]}); // R19
  wire [7:0] ctrl_rd = {ctrl_r[7:3], reload_flag_r, load_enable_r, ctrl_r[B_RUN]};

  // prescaled counter tick and reload boundary
  wire [PSC_W-1:0] psc_top = PSC_W'((1 << ps_act_r) - 1); // R3
  wire tick = run && psc_r == psc_top;
  wire at_top = cnt_r >= mod_act_r;
  wire start = tick && (cnt_r == CNT_ZERO || (center ? (down_r && cnt_r <= CNT_ONE) : at_top));
  wire load = start && load_enable_r; // R21

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ap_addr == A_CTRL) begin
      rd_mux[7:0] = ctrl_rd;
    end else if (ap_addr == A_CFG) begin
      rd_mux[PS_W+1:0] = cfg_r;
    end else if (ap_addr == A_MOD) begin
      rd_mux[CNT_W-1:0] = mod_buf_r;
    end else if (ap_addr == A_MAP) begin
      rd_mux[2*CH_N-1:0] = map_r;
    end else if (ap_addr == A_SWC) begin
      rd_mux[PAIR_N-1:0] = swc_r;
    end else if (ap_addr == A_DT) begin
      rd_mux[DT_W-1:0] = dt_r;
    end else if (ap_addr == A_STAT) begin
      rd_mux[CNT_W-1:0] = cnt_r;
      rd_mux[STAT_SENS+PAIR_N-1:STAT_SENS] = sens_s_r;
    end else begin
      for (int i = 0; i < CH_N; i++) begin
        if (ap_addr == A_VAL0 + 8'(i) * A_VSTEP) begin
          rd_mux[CNT_W-1:0] = val_buf_r[i];
        end
      end
    end
  end

  // bus phase tracking and read data
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_r <= ap && hwrite;
      if (ap) begin
        addr_r <= ap_addr;
      end
      if (ap && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // control register, load enable, reload flag and its clear sequence
  wire flag_clr = wr_ctrl && !hwdata[B_FLAG] && armed_r && !start; // R16 R17
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST;
      load_enable_r <= 1'b0;
      reload_flag_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[7:0]; // R8
      end
      if (load) begin
        load_enable_r <= 1'b0;
      end else if (wr_ctrl) begin
        load_enable_r <= hwdata[B_LDE];
      end
      if (start) begin
        reload_flag_r <= 1'b1; // R15
      end else if (flag_clr) begin
        reload_flag_r <= 1'b0;
      end
      if (start || wr_ctrl) begin
        armed_r <= 1'b0; // R17
      end else if (rd_ctrl && reload_flag_r) begin
        armed_r <= 1'b1; // R16
      end
    end
  end

  // irq follows flag and enable; clearing either withdraws it
  assign reload_irq = reload_flag_r && ctrl_r[B_IEN]; // R13 R14 R18

  // configuration, buffered values and write-once map
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cfg_r <= '0;
      mod_buf_r <= MOD_RST;
      map_r <= '0;
      map_done_r <= 1'b0;
      swc_r <= '0;
      dt_r <= '0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= hwdata[PS_W+1:0]; // R4
      end
      if (wr_mod) begin
        mod_buf_r <= hwdata[CNT_W-1:0];
      end
      if (wr_map && !map_done_r) begin
        map_r <= hwdata[2*CH_N-1:0]; // R12
        map_done_r <= 1'b1;
      end
      if (wr_swc) begin
        swc_r <= hwdata[PAIR_N-1:0];
      end
      if (wr_dt) begin
        dt_r <= hwdata[DT_W-1:0];
      end
    end
  end

  // active modulus and prescaler change only at a reload with load enable
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mod_act_r <= MOD_RST;
      ps_act_r <= '0;
    end else if (load) begin
      mod_act_r <= mod_buf_r; // R21
      ps_act_r <= cfg_r[F_PS+PS_W-1:F_PS];
    end
  end

  // prescaler and shared up or up/down counter
  always_ff @(posedge mclk) begin
    if (!rstn || !run) begin
      psc_r <= '0;
      cnt_r <= CNT_ZERO;
      down_r <= 1'b0;
    end else begin
      psc_r <= tick ? '0 : psc_r + 1'b1; // R3
      if (start) begin
        cnt_r <= CNT_ONE; // R1 R20
        down_r <= 1'b0;
      end else if (tick && !down_r && at_top) begin
        cnt_r <= center ? cnt_r - 1'b1 : cnt_r; // R20
        down_r <= center;
      end else if (tick) begin
        cnt_r <= down_r ? cnt_r - 1'b1 : cnt_r + 1'b1; // R2
      end
    end
  end

  // current sense: two-flop sync, and a copy latched per cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sens_m_r <= '0;
      sens_s_r <= '0;
      sens_l_r <= '0;
    end else begin
      sens_m_r <= cur_sense;
      sens_s_r <= sens_m_r;
      if (start) begin
        sens_l_r <= sens_s_r;
      end
    end
  end

  // disable mask: set at once, released only at a cycle start
  wire [CH_N-1:0] map_x = map_r[CH_N-1:0];
  wire [CH_N-1:0] map_y = map_r[2*CH_N-1:F_MAPY];
  wire [CH_N-1:0] want_x = ctrl_r[B_BANK_X_SOFT_DISABLE] ? map_x : '0; // R10
  wire [CH_N-1:0] want_y = ctrl_r[B_BANK_Y_SOFT_DISABLE] ? map_y : '0; // R11
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mask_r <= '0;
    end else begin
      mask_r <= start ? (want_x | want_y) : (mask_r | want_x | want_y); // R10 R11
    end
  end

  // per-channel value registers and compare
  logic [CH_N-1:0] on_c;
  logic [CH_N-1:0] out_nxt;
  for (genvar i = 0; i < CH_N; i++) begin : g_ch
    wire wr_val = wr_r && addr_r == A_VAL0 + 8'(i) * A_VSTEP;
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        val_buf_r[i] <= '0;
        val_act_r[i] <= '0;
      end else begin
        if (wr_val) begin
          val_buf_r[i] <= hwdata[CNT_W-1:0];
        end
        if (load) begin
          val_act_r[i] <= val_buf_r[i]; // R21
        end
      end
    end
    assign on_c[i] = cnt_r != CNT_ZERO && cnt_r <= val_act_r[i]; // R2
  end

  // complementary pairs: corrected duty, dead time, top/bottom
  for (genvar p = 0; p < PAIR_N; p++) begin : g_pair
    wire pick = (corr == CORR_SW) ? swc_r[p] :
                (corr == CORR_PIN) ? sens_s_r[p] :
                (corr == CORR_LAT) ? sens_l_r[p] : 1'b0; // R6 R7
    wire [CNT_W-1:0] duty = pick ? val_act_r[2*p+1] : val_act_r[2*p];
    wire raw = cnt_r != CNT_ZERO && cnt_r <= duty;
    wire quiet = raw == raw_prev_r[p] && dtc_r[p] == '0; // R5
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        raw_prev_r[p] <= 1'b0;
        dtc_r[p] <= '0;
      end else begin
        raw_prev_r[p] <= raw;
        if (raw != raw_prev_r[p]) begin
          dtc_r[p] <= dt_r; // R5
        end else if (dtc_r[p] != '0) begin
          dtc_r[p] <= dtc_r[p] - 1'b1;
        end
      end
    end
    assign out_nxt[2*p] = run && !mask_r[2*p] &&
                          (indep ? on_c[2*p] : raw && quiet); // R4 R9
    assign out_nxt[2*p+1] = run && !mask_r[2*p+1] &&
                            (indep ? on_c[2*p+1] : !raw && quiet && cnt_r != CNT_ZERO);
  end

  // registered pins
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt; // R9
    end
  end
  assign pwm_out = out_r;

  // checks
  sequence s_clear_try;
    armed_r && wr_ctrl && !hwdata[B_FLAG] && !start;
  endsequence
  sequence s_void_try;
    armed_r && wr_ctrl && !hwdata[B_FLAG] && start;
  endsequence
  a_flag_clear: assert property (@(posedge mclk) disable iff (!rstn) // R16
    s_clear_try |=> !reload_flag_r) else $error("flag not cleared by sequence");
  a_flag_keep: assert property (@(posedge mclk) disable iff (!rstn) // R16
    (reload_flag_r && wr_ctrl && !armed_r && !start) |=> reload_flag_r)
    else $error("flag cleared without prior read");
  a_reload_wins: assert property (@(posedge mclk) disable iff (!rstn) // R17
    s_void_try |=> reload_flag_r) else $error("zero write not voided");
  a_flag_set: assert property (@(posedge mclk) disable iff (!rstn) // R15
    start |=> reload_flag_r) else $error("flag not set at reload");
  a_irq_gate: assert property (@(posedge mclk) disable iff (!rstn) // R14
    $fell(ctrl_r[B_IEN]) |-> !reload_irq) else $error("irq not blocked");
  a_irq_pend: assert property (@(posedge mclk) disable iff (!rstn) // R13
    (start && ctrl_r[B_IEN] && !wr_ctrl) |=> reload_irq) else $error("irq not pending");
  a_bank_x_soft_disable_force: assert property (@(posedge mclk) disable iff (!rstn) // R10
    ($rose(ctrl_r[B_BANK_X_SOFT_DISABLE]) && !wr_ctrl) |-> ##2 ((pwm_out & map_x) == '0))
    else $error("bank x pins not forced off");
  a_bank_y_soft_disable_hold: assert property (@(posedge mclk) disable iff (!rstn) // R11
    ($fell(ctrl_r[B_BANK_Y_SOFT_DISABLE]) && !start && !ctrl_r[B_BANK_X_SOFT_DISABLE]) |=> ((mask_r & map_y) == map_y))
    else $error("bank y released before cycle start");
  a_map_once: assert property (@(posedge mclk) disable iff (!rstn) // R12
    map_done_r |=> $stable(map_r)) else $error("map changed after first write");
  a_dead_gap: assert property (@(posedge mclk) disable iff (!rstn) // R5
    !indep |-> (pwm_out[0] && pwm_out[1]) == 1'b0) else $error("pair overlap");
  a_dead_len: assert property (@(posedge mclk) disable iff (!rstn) // R5
    (!indep && dt_r != '0 && $fell(pwm_out[0])) |=> !pwm_out[1])
    else $error("bottom on without dead time");
  // stopped counter, buffered values and load enable hand-off
  a_run_idle: assert property (@(posedge mclk) disable iff (!rstn) // R8
    !run |=> pwm_out == '0) else $error("pins active while stopped");
  a_load_hold: assert property (@(posedge mclk) disable iff (!rstn) // R21
    !load |=> ($stable(mod_act_r) && $stable(ps_act_r)))
    else $error("active value changed off reload");
  a_load_clear: assert property (@(posedge mclk) disable iff (!rstn) // R21
    load |=> !load_enable_r) else $error("load enable not consumed");
  a_edge_wrap: assert property (@(posedge mclk) disable iff (!rstn) // R20
    (start && !load) |=> cnt_r == CNT_ONE ##1 (cnt_r <= mod_act_r || cnt_r == CNT_ONE))
    else $error("counter did not restart at one");
endmodule
`default_nettype wire

// [verification/mcp_stage.sv]
// power stage model: phase current polarity source and leg shoot-through watch
`default_nettype none
module mcp_stage
  import mcp_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pol,
  input wire logic comp,
  input wire logic [mcp_pkg::CH_N-1:0] pwm_out,
  output logic [mcp_pkg::PAIR_N-1:0] cur_sense,
  output int overlap_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // every phase current follows the commanded sign
  assign cur_sense = {PAIR_N{pol}};
  // both switches of one leg on together would short the supply
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      overlap_n <= 0;
    end else begin
      for (int p = 0; p < PAIR_N; p++) begin
        if (comp && pwm_out[2*p] === 1'b1 && pwm_out[2*p+1] === 1'b1) begin
          overlap_n <= overlap_n + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verification/motor_control_pwm_unit_tb_top.sv]
// self-checking bench of the motor-control pwm unit
`default_nettype none
module motor_control_pwm_unit_tb_top;
  import mcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic pol = 1'b0;
  logic comp = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready;
  logic hresp;
  logic reload_irq;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [CH_N-1:0] pwm_out;
  logic [PAIR_N-1:0] cur_sense;
  int overlap_n;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  mcp_unit u_mcp_unit (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .cur_sense(cur_sense), .pwm_out(pwm_out),
    .reload_irq(reload_irq));
  mcp_stage u_mcp_stage (.mclk(mclk), .rstn(rstn), .pol(pol), .comp(comp), .pwm_out(pwm_out),
    .cur_sense(cur_sense), .overlap_n(overlap_n));
  // free-running 50 mhz clock
  initial begin
    forever #10 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one single ahb-lite transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0000_0000);
  endtask
  // high cycles of one pin over n settled samples
  task automatic hi(input int b, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge mclk);
      if (pwm_out[b] === 1'b1) c++;
      else if (pwm_out[b] !== 1'b0) c += 1000;
    end
  endtask
  task automatic t_reset;
    rd(A_CTRL);
    chk("ctrl", {24'h00_0000, CTRL_RST}, q);
    rd(A_MOD);
    chk("modulus", {20'h0_0000, MOD_RST}, q);
    rd(8'h40);
    chk("unmapped", 32'h0000_0000, q);
    chk("irq", 32'h0000_0000, {31'h0, reload_irq});
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask
  task automatic t_map;
    wr(A_MAP, 32'h0000_0081);
    wr(A_MAP, 32'h0000_0FFF);
    rd(A_MAP);
    chk("map", 32'h0000_0081, q);
  endtask
  task automatic t_edge;
    int c;
    wr(A_CFG, 32'h0000_0002);
    wr(A_MOD, 32'h0000_0004);
    wr(A_VAL0, 32'h0000_0002);
    wr(A_VAL0 + A_VSTEP, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_000B);
    repeat (12) @(negedge mclk);
    rd(A_CTRL);
    chk("ctrl run", 32'h0000_000D, q);
    @(negedge mclk);
    chk("irq on", 32'h0000_0001, {31'h0, reload_irq});
    hi(0, 8, c);
    chk("ch0 high", 32'h0000_0004, c);
    hi(1, 8, c);
    chk("ch1 high", 32'h0000_0004, c);
  endtask
  task automatic t_disable;
    int c;
    wr(A_CTRL, 32'h0000_0089);
    repeat (2) @(negedge mclk);
    hi(0, 8, c);
    chk("x off ch0", 32'h0000_0000, c);
    hi(1, 8, c);
    chk("x off ch1", 32'h0000_0004, c);
    wr(A_CTRL, 32'h0000_00C9);
    repeat (2) @(negedge mclk);
    hi(1, 8, c);
    chk("y off ch1", 32'h0000_0000, c);
    wr(A_CTRL, 32'h0000_0009);
    repeat (6) @(negedge mclk);
    hi(0, 8, c);
    chk("x back", 32'h0000_0004, c);
    hi(1, 8, c);
    chk("y back", 32'h0000_0004, c);
  endtask
  task automatic t_flag;
    rd(A_CTRL);
    repeat (10) @(negedge mclk);
    wr(A_CTRL, 32'h0000_0009);
    rd(A_CTRL);
    chk("flag kept", 32'h0000_000D, q);
    wr(A_CTRL, 32'h0000_0001);
    @(negedge mclk);
    chk("irq masked", 32'h0000_0000, {31'h0, reload_irq});
    wr(A_CTRL, 32'h0000_0008);
    @(negedge mclk);
    chk("irq back", 32'h0000_0001, {31'h0, reload_irq});
    rd(A_CTRL);
    chk("armed read", 32'h0000_000C, q);
    wr(A_CTRL, 32'h0000_0008);
    rd(A_CTRL);
    chk("flag clear", 32'h0000_0008, q);
    chk("irq gone", 32'h0000_0000, {31'h0, reload_irq});
  endtask
  task automatic t_comp;
    int c0;
    int c1;
    int cb;
    comp <= 1'b1;
    wr(A_CFG, 32'h0000_0001);
    wr(A_MOD, 32'h0000_0008);
    wr(A_VAL0, 32'h0000_0002);
    wr(A_VAL0 + A_VSTEP, 32'h0000_0006);
    wr(A_DT, 32'h0000_0001);
    wr(A_CTRL, 32'h0000_0023);
    repeat (40) @(negedge mclk);
    hi(0, 32, c0);
    hi(1, 32, cb);
    @(posedge mclk);
    pol <= 1'b1;
    repeat (40) @(negedge mclk);
    hi(0, 32, c1);
    chk("sense duty", 32'h0000_0001, {31'h0, c1 != c0});
    chk("bottom on", 32'h0000_0001, {31'h0, cb != 0});
    chk("overlap", 32'h0000_0000, overlap_n);
    rd(A_STAT);
    chk("sense stat", 32'h0000_0007, (q >> STAT_SENS) & 32'h0000_0007);
    wr(A_CTRL, 32'h0000_0011);
    repeat (20) @(negedge mclk);
    hi(0, 32, c0);
    wr(A_SWC, 32'h0000_0001);
    repeat (20) @(negedge mclk);
    hi(0, 32, c1);
    chk("sw corr", 32'h0000_0001, {31'h0, c1 > c0});
    wr(A_SWC, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0031);
    repeat (40) @(negedge mclk);
    hi(0, 32, c1);
    chk("latched corr", 32'h0000_0001, {31'h0, c1 > c0});
  endtask
  task automatic t_presc;
    int c;
    comp <= 1'b0;
    wr(A_CFG, 32'h0000_0006);
    wr(A_MOD, 32'h0000_0004);
    wr(A_CTRL, 32'h0000_0003);
    repeat (40) @(negedge mclk);
    hi(0, 16, c);
    chk("prescaled ch0", 32'h0000_0008, c);
  endtask
  task automatic summarize;
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_map();
    t_edge();
    t_disable();
    t_flag();
    t_comp();
    t_presc();
    summarize();
  end
endmodule
`default_nettype wire
